// ---- common/uie_defines.vh ----
`ifndef UIE_DEFINES_VH
`define UIE_DEFINES_VH
// Register addresses (16-bit device address space).
`define UIE_ADDR_CONFIG 16'hff80
`define UIE_ADDR_BCOUNT 16'hff81
`define UIE_ADDR_IRQ_STATUS 16'hff84
`define UIE_ADDR_IRQ_ENABLE 16'hff85
`define UIE_ADDR_IRQ_CLEAR 16'hff86
// Fixed data buffer base.
`define UIE_BUF_BASE 16'hfef8
// Configuration field positions.
`define UIE_CFG_IRQ_EN 2
`define UIE_CFG_STALL 3
`define UIE_CFG_SEQ 5
`define UIE_CFG_BME 7
// Byte count field layout.
`define UIE_BC_NAK 7
`define UIE_BC_MAX 4'h8
// Reset values.
`define UIE_CFG_RESET 8'h00
`define UIE_BC_RESET 8'h80
// Handshake answers.
`define UIE_RESP_NONE 2'h0
`define UIE_RESP_DATA 2'h1
`define UIE_RESP_NAK 2'h2
`define UIE_RESP_STALL 2'h3
// Interrupt status bits.
`define UIE_IRQ_XFER 0
`define UIE_IRQ_SETUP 1
`endif

// ---- hw/uie_sync2.v ----
`timescale 1ns/100ps
// Two-stage synchroniser for pulses and levels arriving from outside mclk.
module uie_sync2 #(
    parameter WIDTH = 1
) (
    input wire mclk,
    input wire reset,
    input wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            s1_q <= {WIDTH{1'b0}};
            s2_q <= {WIDTH{1'b0}};
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end
    assign q = s2_q;
endmodule

// ---- hw/uie_ep0_in.v ----
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`include "uie_defines.vh"
// How it works
// - While the stall and manager-enable bits are both set every IN request on this endpoint is answered with STALL.
// - The stall bit clears itself when the next SETUP arrives, with no software write.
// - The buffer manager serves this endpoint only while the manager-enable bit is set.
// - The byte-count field is a plain 4-bit binary count 0 to 15 and resets to zero.
// - A byte count of 9 to 15 is sent as 8 bytes.
// - With the ownership bit at 0 the buffer holds a packet that is sent on the next IN.
// - With the ownership bit at 1, its reset value, IN requests get NAK.
// - IN data is always fetched from the fixed buffer base address.
module uie_ep0_in (
    // Clock and reset
    input wire mclk,
    input wire reset,
    // Register port
    input wire [15:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Link events from the USB engine (asynchronous, level-held pulses)
    input wire link_in_token,
    input wire link_setup_token,
    input wire link_host_ack,
    // Answer to the USB engine
    output reg [1:0] resp_kind,
    output reg resp_valid,
    output reg resp_seq,
    output reg [3:0] resp_len,
    output reg [15:0] resp_base,
    // Interrupt
    output wire irq
);
    // ----------------------------------------
    // Event synchronisation and edge detection
    // ----------------------------------------
    wire [2:0] ev_sync;
    reg [2:0] ev_prev_q;
    wire [2:0] ev_rise;
    uie_sync2 #(
        .WIDTH(3)
    ) u_sync (
        .mclk(mclk),
        .reset(reset),
        .d({link_host_ack, link_setup_token, link_in_token}),
        .q(ev_sync)
    );
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            ev_prev_q <= 3'h0;
        end else begin
            ev_prev_q <= ev_sync;
        end
    end
    assign ev_rise = ev_sync & ~ev_prev_q;
    wire in_ev = ev_rise[0];
    wire setup_ev = ev_rise[1];
    wire ack_ev = ev_rise[2];

    // ----------------------------------------
    // Reset values and register decode
    // ----------------------------------------
    // Reset images of the two endpoint registers; fields are picked out by position.
    localparam [7:0] CFG_RST = `UIE_CFG_RESET;
    localparam [7:0] BC_RST = `UIE_BC_RESET;
    wire wr_cfg = reg_wr && (reg_addr == `UIE_ADDR_CONFIG);
    wire wr_bc = reg_wr && (reg_addr == `UIE_ADDR_BCOUNT);
    wire wr_ien = reg_wr && (reg_addr == `UIE_ADDR_IRQ_ENABLE);
    wire wr_iclr = reg_wr && (reg_addr == `UIE_ADDR_IRQ_CLEAR);

    // ----------------------------------------
    // Configuration register
    // ----------------------------------------
    reg irq_en_q;
    reg irq_en_d;
    reg stall_q;
    reg stall_d;
    reg bme_q;
    reg bme_d;
    // Endpoint live only with the manager enabled.
    wire ep_on = bme_q;

    always @* begin
        irq_en_d = irq_en_q;
        stall_d = stall_q;
        bme_d = bme_q;
        if (wr_cfg) begin
            irq_en_d = reg_wdata[`UIE_CFG_IRQ_EN];
            stall_d = reg_wdata[`UIE_CFG_STALL];
            bme_d = reg_wdata[`UIE_CFG_BME];
        end
        // SETUP beats a same-cycle write, so a late write cannot re-arm a stall that the host has cleared.
        if (setup_ev) begin
            stall_d = 1'b0;
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_en_q <= CFG_RST[`UIE_CFG_IRQ_EN];
            stall_q <= CFG_RST[`UIE_CFG_STALL];
            bme_q <= CFG_RST[`UIE_CFG_BME];
        end else begin
            irq_en_q <= irq_en_d;
            stall_q <= stall_d;
            bme_q <= bme_d;
        end
    end

    // ----------------------------------------
    // Packet in flight
    // ----------------------------------------
    // Set when DATA goes out, cleared by the ACK or by a SETUP that aborts the stage.
    reg sent_q;
    reg sent_d;
    // Only an ACK that follows our own DATA packet completes a transfer.
    wire ack_done = ep_on && sent_q && ack_ev;

    // ----------------------------------------
    // Data sequence bit
    // ----------------------------------------
    reg seq_q;
    reg seq_d;

    // SETUP restarts the data stage at DATA1.
    always @* begin
        seq_d = seq_q;
        if (setup_ev) begin
            seq_d = 1'b1;
        end else if (ack_done) begin
            seq_d = ~seq_q;
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            seq_q <= CFG_RST[`UIE_CFG_SEQ];
        end else begin
            seq_q <= seq_d;
        end
    end

    // ----------------------------------------
    // Byte count register
    // ----------------------------------------
    reg nak_q;
    reg nak_d;
    reg [3:0] count_q;
    reg [3:0] count_d;
    // The stored count is kept as written; only what goes on the wire is capped.
    wire [3:0] eff_count = (count_q > `UIE_BC_MAX) ? `UIE_BC_MAX : count_q;

    always @* begin
        nak_d = nak_q;
        count_d = count_q;
        if (wr_bc) begin
            nak_d = reg_wdata[`UIE_BC_NAK];
            count_d = reg_wdata[3:0];
        end
        // The ACK wins over a same-cycle write, so a delivered packet is never sent twice.
        if (ack_done) begin
            nak_d = 1'b1;
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            nak_q <= BC_RST[`UIE_BC_NAK];
            count_q <= BC_RST[3:0];
        end else begin
            nak_q <= nak_d;
            count_q <= count_d;
        end
    end

    // ----------------------------------------
    // IN request answer
    // ----------------------------------------
    reg [1:0] resp_kind_d;
    reg resp_valid_d;
    reg resp_seq_d;
    reg [3:0] resp_len_d;
    reg [15:0] resp_base_d;

    // Priority is stall, then NAK, then data; the answer fields hold until the next IN.
    always @* begin
        resp_kind_d = resp_kind;
        resp_valid_d = 1'b0;
        resp_seq_d = resp_seq;
        resp_len_d = resp_len;
        resp_base_d = resp_base;
        sent_d = sent_q;
        if (setup_ev || ack_ev) begin
            sent_d = 1'b0;
        end
        if (in_ev && ep_on) begin
            resp_valid_d = 1'b1;
            resp_seq_d = seq_q;
            resp_base_d = `UIE_BUF_BASE;
            if (stall_q) begin
                resp_kind_d = `UIE_RESP_STALL;
                resp_len_d = 4'h0;
            end else if (nak_q) begin
                resp_kind_d = `UIE_RESP_NAK;
                resp_len_d = 4'h0;
            end else begin
                resp_kind_d = `UIE_RESP_DATA;
                resp_len_d = eff_count;
                sent_d = 1'b1;
            end
        end
    end

    // The base output only carries meaning once the first answer has gone out.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            resp_kind <= `UIE_RESP_NONE;
            resp_valid <= 1'b0;
            resp_seq <= 1'b0;
            resp_len <= 4'h0;
            resp_base <= 16'h0000;
            sent_q <= 1'b0;
        end else begin
            resp_kind <= resp_kind_d;
            resp_valid <= resp_valid_d;
            resp_seq <= resp_seq_d;
            resp_len <= resp_len_d;
            resp_base <= resp_base_d;
            sent_q <= sent_d;
        end
    end

    // ----------------------------------------
    // Interrupt enable and clear
    // ----------------------------------------
    reg [1:0] irq_enable_q;
    reg [1:0] irq_enable_d;
    wire [1:0] irq_set;
    wire [1:0] irq_clr;
    wire [1:0] irq_status;
    // Transfer flag: only ACKed data packets, and only with the configuration enable set.
    assign irq_set[`UIE_IRQ_XFER] = ack_done && irq_en_q;
    // SETUP flag: lets firmware see a new control transfer even while the endpoint is stalled.
    assign irq_set[`UIE_IRQ_SETUP] = setup_ev && ep_on;
    // Write-one-to-clear: a zero in the clear word leaves the flag alone.
    assign irq_clr = wr_iclr ? reg_wdata[1:0] : 2'h0;

    always @* begin
        irq_enable_d = irq_enable_q;
        if (wr_ien) begin
            irq_enable_d = reg_wdata[1:0];
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_enable_q <= 2'h0;
        end else begin
            irq_enable_q <= irq_enable_d;
        end
    end

    // ----------------------------------------
    // Interrupt status flags
    // ----------------------------------------
    // A set in the same cycle as its clear survives, so no event is lost to a late clear.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
            reg flag_q;
            reg flag_d;

            always @* begin
                flag_d = flag_q;
                if (irq_clr[gi]) begin
                    flag_d = 1'b0;
                end
                if (irq_set[gi]) begin
                    flag_d = 1'b1;
                end
            end

            always @(posedge mclk or posedge reset) begin
                if (reset) begin
                    flag_q <= 1'b0;
                end else begin
                    flag_q <= flag_d;
                end
            end

            assign irq_status[gi] = flag_q;
        end
    endgenerate
    // Level output: stays high while any enabled flag is set.
    assign irq = |(irq_status & irq_enable_q);

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    reg [7:0] cfg_view;
    reg [7:0] bc_view;
    reg [7:0] rdata_d;

    // Reserved bits read as zero.
    always @* begin
        cfg_view = 8'h00;
        cfg_view[`UIE_CFG_IRQ_EN] = irq_en_q;
        cfg_view[`UIE_CFG_STALL] = stall_q;
        cfg_view[`UIE_CFG_SEQ] = seq_q;
        cfg_view[`UIE_CFG_BME] = bme_q;
        bc_view = 8'h00;
        bc_view[`UIE_BC_NAK] = nak_q;
        bc_view[3:0] = count_q;
    end

    // Data stand only in the cycle after the strobe; the bus is zero otherwise.
    always @* begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `UIE_ADDR_CONFIG: rdata_d = cfg_view;
                `UIE_ADDR_BCOUNT: rdata_d = bc_view;
                `UIE_ADDR_IRQ_STATUS: rdata_d = {6'h00, irq_status};
                `UIE_ADDR_IRQ_ENABLE: rdata_d = {6'h00, irq_enable_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_d;
        end
    end
endmodule

// ---- tb/uie_ep0_in_checker.sv ----
`timescale 1ns/100ps
module uie_ep0_in_checker (
    // Clock, reset, register port
    input logic mclk,
    input logic reset,
    input logic [15:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    // Answer and interrupt
    input logic [1:0] resp_kind,
    input logic resp_valid,
    input logic [3:0] resp_len,
    input logic [15:0] resp_base,
    input logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Shadows of the enable bits, so answers tie to what software set.
    logic bme_q;
    logic ien_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bme_q <= 1'b0;
            ien_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == 16'hff80) begin
                bme_q <= reg_wdata[7];
            end
            if (reg_wr && reg_addr == 16'hff85) begin
                ien_q <= |reg_wdata[1:0];
            end
        end
    end
    // The answer reflects the enable as it stood in the cycle the request was seen.
    bme_gate_a: assert property (resp_valid |-> $past(bme_q))
        else $error("answer while disabled");
    len_cap_a: assert property (resp_valid && resp_kind == 2'h1 |-> resp_len <= 4'h8)
        else $error("length above 8");
    nak_len_a: assert property (resp_valid && resp_kind != 2'h1 |-> resp_len == 4'h0)
        else $error("length on handshake");
    base_fixed_a: assert property (resp_valid |-> resp_base == 16'hfef8)
        else $error("wrong base");
    kind_set_a: assert property (resp_valid |-> resp_kind != 2'h0)
        else $error("empty answer");
    pulse_once_a: assert property (resp_valid |=> !resp_valid && $stable(resp_kind))
        else $error("answer not one cycle");
    irq_gate_a: assert property (irq |-> ien_q)
        else $error("irq while masked");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("stray read data");
endmodule
bind uie_ep0_in uie_ep0_in_checker chk_i (
    .mclk(mclk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .resp_kind(resp_kind),
    .resp_valid(resp_valid),
    .resp_len(resp_len),
    .resp_base(resp_base),
    .irq(irq)
);

// ---- tb/uie_host.sv ----
`timescale 1ns/100ps
module uie_host (
    // Clock
    input wire logic mclk,
    // Host events
    output wire logic link_in_token,
    output wire logic link_setup_token,
    output wire logic link_host_ack
);
    logic [2:0] ev = 3'h0;
    assign {link_host_ack, link_setup_token, link_in_token} = ev;
    // Long high and low spans so the two-flop sync never drops an edge.
    task automatic send(input int k);
        @(posedge mclk);
        ev[k] <= 1'b1;
        repeat (3) @(posedge mclk);
        ev[k] <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
endmodule

// ---- tb/uie_ep0_in_tb_top.sv ----
`timescale 1ns/100ps
module uie_ep0_in_tb_top;
    logic mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, resp_valid, resp_seq, rs, irq;
    logic link_in_token, link_setup_token, link_host_ack;
    logic [15:0] reg_addr = 0, resp_base;
    logic [7:0] reg_wdata = 0, reg_rdata, n = 0, ne = 0;
    logic [1:0] resp_kind, rk;
    logic [3:0] resp_len, rl;
    int miscompares = 0, samples_checked = 0;
    always #2 mclk = ~mclk;
    uie_host host (
        .mclk(mclk),
        .link_in_token(link_in_token),
        .link_setup_token(link_setup_token),
        .link_host_ack(link_host_ack)
    );
    uie_ep0_in dut (
        .mclk(mclk),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .link_in_token(link_in_token),
        .link_setup_token(link_setup_token),
        .link_host_ack(link_host_ack),
        .resp_kind(resp_kind),
        .resp_valid(resp_valid),
        .resp_seq(resp_seq),
        .resp_len(resp_len),
        .resp_base(resp_base),
        .irq(irq)
    );
    always @(posedge mclk)
        if (resp_valid === 1'b1) begin
            {rk, rl, rs} <= {resp_kind, resp_len, resp_seq};
            n <= n + 8'h01;
        end
    task automatic chk(input logic [7:0] g, e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // Expected answer as {0, kind, length, sequence}; zero means none.
    task automatic in_chk(input logic [7:0] e);
        host.send(0);
        ne = ne + (e != 8'h00);
        chk(n, ne);
        if (e != 8'h00) chk({1'b0, rk, rl, rs & (rk == 2'h1)}, e);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        rd(16'hff80, 8'h00);
        rd(16'hff81, 8'h80);
        rd(16'hff90, 8'h00);
        in_chk(8'h00);
        $display("test 1 done");
        wr(16'hff80, 8'h84);
        wr(16'hff85, 8'h01);
        rd(16'hff85, 8'h01);
        in_chk(8'h40);
        wr(16'hff81, 8'h0f);
        in_chk(8'h30);
        host.send(2);
        rd(16'hff81, 8'h8f);
        rd(16'hff80, 8'ha4);
        chk({7'h00, irq}, 8'h01);
        wr(16'hff86, 8'h03);
        chk({7'h00, irq}, 8'h00);
        $display("test 2 done");
        wr(16'hff80, 8'h8c);
        in_chk(8'h60);
        host.send(1);
        rd(16'hff80, 8'ha4);
        in_chk(8'h40);
        $display("test 3 done");
        wr(16'hff80, 8'h80);
        wr(16'hff81, 8'h03);
        in_chk(8'h27);
        host.send(2);
        rd(16'hff84, 8'h02);
        rd(16'hff80, 8'h80);
        $display("test 4 done");
        wrap_up;
    end
    initial begin
        #20000;
        miscompares++;
        wrap_up;
    end
endmodule
